// ==== hdl/pbp_pkg.sv ====
// constants, types and command codes for the periodic buffer port block
// assumes one 40 MHz clock and a host that issues one command then data words
// Operation
// RULE1: one iso size serves buffers A and B
// RULE2: iso size is 16-bit RW, resets zero
// RULE3: iso size read 30h, write B0h
// RULE4: buffer A port starts at address zero
// RULE5: buffer B port starts at address zero
// RULE6: interrupt buffer port starts at address zero
// RULE7: 40h reads buffer A, C0h writes it
// RULE8: 42h reads buffer B, C2h writes it
// RULE9: 43h reads interrupt buffer, C3h writes it
// RULE10: host loads counter, checks status first
// RULE11: host moves words without resending command
// RULE12: each word advances the buffer pointer
// RULE13: count reached sets end flag, updates status
// RULE14: data ports are 16-bit, reset zero
// RULE15: toggle interval 0-15 ms, 4 bits
// RULE16: toggle read 47h, write C7h
// RULE17: interrupt size defaults 128, max 4096
// RULE18: interrupt size read 33h, write B3h
// RULE19: buffer B also raises end flag
// RULE20: direct port gives random buffer access
// RULE21: toggle reserved bits read zero
// RULE22: new command restarts pointer at zero; the code starts a direct port command at its setup address
package pbp_pkg;
  localparam logic [7:0]  CMD_ISO_SIZE   = 8'h30;
  localparam logic [7:0]  CMD_DIR_SETUP  = 8'h32;
  localparam logic [7:0]  CMD_INT_SIZE   = 8'h33;
  localparam logic [7:0]  CMD_ISO_A      = 8'h40;
  localparam logic [7:0]  CMD_ISO_B      = 8'h42;
  localparam logic [7:0]  CMD_INT_BUF    = 8'h43;
  localparam logic [7:0]  CMD_DIR_DATA   = 8'h45;
  localparam logic [7:0]  CMD_TOGGLE     = 8'h47;
  localparam int          CMD_WR_BIT     = 7;
  localparam logic [15:0] ISO_SIZE_RST   = 16'h0000;
  localparam logic [15:0] INT_SIZE_RST   = 16'h0080;
  localparam logic [15:0] INT_SIZE_MAX   = 16'h1000;
  localparam logic [3:0]  TOGGLE_RST     = 4'h0;
  localparam int          TOGGLE_W       = 4;
  localparam logic [15:0] PORT_RST       = 16'h0000;
  localparam logic [31:0] DIR_SETUP_RST  = 32'h0000_0000;
  localparam int          DIR_ADDR_LSB   = 0;
  localparam int          DIR_ADDR_W     = 15;
  localparam int          DIR_CNT_LSB    = 16;
  localparam logic [16:0] BYTES_PER_WORD = 17'h00002;
  localparam int          ST_A           = 0;
  localparam int          ST_B           = 1;
  localparam int          ST_INT         = 2;
  localparam int          ST_DIR         = 3;

  typedef enum logic [3:0] {
    TGT_NONE, TGT_ISO_SIZE, TGT_INT_SIZE, TGT_TOGGLE, TGT_DIR_SETUP,
    TGT_ISO_A, TGT_ISO_B, TGT_INT_BUF, TGT_DIR_DATA
  } pbp_tgt_type;

  typedef enum logic [2:0] {
    PS_IDLE, PS_REG_RD, PS_REG_WR, PS_BUF_RD, PS_BUF_WR
  } pbp_state_type;

  typedef struct packed {
    logic        sel_a;
    logic        sel_b;
    logic        sel_int;
    logic        direct;
    logic [14:0] addr;
    logic        we;
    logic [15:0] wdata;
  } pbp_mem_req_type;
endpackage

// ==== hdl/pbp_buffer_port.sv ====
// command-addressed size/toggle registers and auto-incrementing buffer ports
// assumes the buffer memory answers mem_rdata in the same cycle as mem_req.addr
module pbp_buffer_port #(
  parameter int ADDR_W = 15
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  // host command and data port
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_code,
  input  wire logic                     wr_valid,
  input  wire logic [15:0]              wr_data,
  input  wire logic                     rd_req,
  output logic [15:0]                   rd_data,
  output logic                          rd_valid,
  // transfer counter value and completion events
  input  wire logic [15:0]              transfer_byte_count,
  output logic                          end_of_transfer_flag,
  output logic [3:0]                    status_update,
  // configuration seen by the scheduler
  output logic [15:0]                   iso_size_a,
  output logic [15:0]                   iso_size_b,
  output logic [15:0]                   int_size,
  output logic [3:0]                    toggle_interval,
  // buffer memory
  output pbp_pkg::pbp_mem_req_type      mem_req,
  input  wire logic [15:0]              mem_rdata
);
  import pbp_pkg::*;

  if (ADDR_W != DIR_ADDR_W) begin : g_chk
    $error("pbp_buffer_port: ADDR_W must equal the 15-bit buffer address width");
  end

  pbp_state_type  state_reg;
  pbp_tgt_type    tgt_reg;
  pbp_tgt_type    cmd_tgt;
  logic           cmd_wr;
  logic [15:0]    iso_size_reg;
  logic [15:0]    int_size_reg;
  logic [3:0]     toggle_reg;
  logic [31:0]    dir_setup_reg;
  logic           half_reg;
  logic [14:0]    ptr_reg;
  logic [16:0]    bytes_reg;
  logic [16:0]    bytes_next;
  logic [16:0]    limit;
  logic           xfer;
  logic           last;
  logic           reg_done;
  logic [15:0]    reg_rd_val;
  logic [15:0]    rd_data_reg;
  logic           rd_valid_reg;
  logic           eot_reg;
  logic [3:0]     status_reg;

  function automatic pbp_tgt_type decode_tgt(input logic [7:0] code);
    logic [7:0] base;
    base = {1'b0, code[6:0]};
    if (base == CMD_ISO_SIZE) decode_tgt = TGT_ISO_SIZE;
    else if (base == CMD_INT_SIZE) decode_tgt = TGT_INT_SIZE;
    else if (base == CMD_TOGGLE) decode_tgt = TGT_TOGGLE;
    else if (base == CMD_DIR_SETUP) decode_tgt = TGT_DIR_SETUP;
    else if (base == CMD_ISO_A) decode_tgt = TGT_ISO_A;
    else if (base == CMD_ISO_B) decode_tgt = TGT_ISO_B;
    else if (base == CMD_INT_BUF) decode_tgt = TGT_INT_BUF;
    else if (base == CMD_DIR_DATA) decode_tgt = TGT_DIR_DATA;
    else decode_tgt = TGT_NONE;
  endfunction

  function automatic logic is_buf(input pbp_tgt_type t);
    is_buf = (t == TGT_ISO_A) || (t == TGT_ISO_B) || (t == TGT_INT_BUF) ||
             (t == TGT_DIR_DATA);
  endfunction

  // RULE3 RULE7 RULE8 RULE9 RULE16 RULE18
  assign cmd_tgt = decode_tgt(cmd_code);
  assign cmd_wr  = cmd_code[CMD_WR_BIT];

  // words move only inside an open burst; RULE11 the command is not resent
  assign xfer = ((state_reg == PS_BUF_WR) && wr_valid) ||
                ((state_reg == PS_BUF_RD) && rd_req);
  assign bytes_next = bytes_reg + BYTES_PER_WORD;
  // direct port counts against its own setup; the others use the counter RULE10
  assign limit = (tgt_reg == TGT_DIR_DATA) ?
                 {1'b0, dir_setup_reg[DIR_CNT_LSB +: 16]} : {1'b0, transfer_byte_count};
  // odd counts finish on the word that covers the last byte
  assign last = xfer && (bytes_next >= limit); // RULE13 RULE19
  // the 32-bit direct setup takes two words, low half first
  assign reg_done = ((state_reg == PS_REG_WR) && wr_valid) ||
                    ((state_reg == PS_REG_RD) && rd_req);

  // command sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= PS_IDLE;
      tgt_reg   <= TGT_NONE;
    end else if (cmd_valid) begin
      // RULE22 a new command drops whatever burst was open
      tgt_reg <= cmd_tgt;
      if (cmd_tgt == TGT_NONE) state_reg <= PS_IDLE;
      else if (is_buf(cmd_tgt)) state_reg <= cmd_wr ? PS_BUF_WR : PS_BUF_RD;
      else state_reg <= cmd_wr ? PS_REG_WR : PS_REG_RD;
    end else if (last) begin
      state_reg <= PS_IDLE;
    end else if (reg_done && !((tgt_reg == TGT_DIR_SETUP) && !half_reg)) begin
      state_reg <= PS_IDLE;
    end
  end

  // half-word select for the direct setup register
  always_ff @(posedge clk) begin
    if (sys_rst) half_reg <= 1'b0;
    else if (cmd_valid) half_reg <= 1'b0;
    else if (reg_done) half_reg <= ~half_reg;
  end

  // buffer pointer and byte progress
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ptr_reg   <= '0;
      bytes_reg <= '0;
    end else if (cmd_valid && is_buf(cmd_tgt)) begin
      bytes_reg <= '0; // RULE22
      // RULE4 RULE5 RULE6 fixed start; RULE20 direct port starts anywhere
      ptr_reg <= (cmd_tgt == TGT_DIR_DATA) ? dir_setup_reg[DIR_ADDR_LSB +: DIR_ADDR_W] : '0;
    end else if (xfer) begin
      ptr_reg   <= ptr_reg + BYTES_PER_WORD[14:0]; // RULE12
      bytes_reg <= bytes_next;
    end
  end

  // size, toggle and direct setup registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      iso_size_reg  <= ISO_SIZE_RST; // RULE2
      int_size_reg  <= INT_SIZE_RST; // RULE17
      toggle_reg    <= TOGGLE_RST;
      dir_setup_reg <= DIR_SETUP_RST;
    end else if ((state_reg == PS_REG_WR) && wr_valid) begin
      if (tgt_reg == TGT_ISO_SIZE) iso_size_reg <= wr_data; // RULE2
      else if (tgt_reg == TGT_INT_SIZE)
        // oversize requests are clamped rather than wrapping the buffer
        int_size_reg <= (wr_data > INT_SIZE_MAX) ? INT_SIZE_MAX : wr_data; // RULE17
      else if (tgt_reg == TGT_TOGGLE) toggle_reg <= wr_data[TOGGLE_W-1:0]; // RULE15 RULE21
      else if (tgt_reg == TGT_DIR_SETUP) begin
        if (half_reg) dir_setup_reg[31:16] <= wr_data;
        else dir_setup_reg[15:0] <= wr_data; // RULE20
      end
    end
  end

  always_comb begin
    reg_rd_val = '0;
    case (tgt_reg)
      TGT_ISO_SIZE:  reg_rd_val = iso_size_reg;
      TGT_INT_SIZE:  reg_rd_val = int_size_reg;
      TGT_TOGGLE:    reg_rd_val = {12'h000, toggle_reg}; // RULE21
      TGT_DIR_SETUP: reg_rd_val = half_reg ? dir_setup_reg[31:16] : dir_setup_reg[15:0];
      default:       reg_rd_val = '0;
    endcase
  end

  // read data path
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_reg  <= PORT_RST; // RULE14
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= 1'b0;
      if ((state_reg == PS_BUF_RD) && rd_req) begin
        rd_data_reg  <= mem_rdata;
        rd_valid_reg <= 1'b1;
      end else if ((state_reg == PS_REG_RD) && rd_req) begin
        rd_data_reg  <= reg_rd_val;
        rd_valid_reg <= 1'b1;
      end
    end
  end

  // completion events, one cycle each
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      eot_reg    <= 1'b0;
      status_reg <= '0;
    end else begin
      eot_reg    <= last; // RULE13 RULE19
      status_reg <= '0;
      if (last) begin
        status_reg[ST_A]   <= (tgt_reg == TGT_ISO_A);
        status_reg[ST_B]   <= (tgt_reg == TGT_ISO_B);
        status_reg[ST_INT] <= (tgt_reg == TGT_INT_BUF);
        status_reg[ST_DIR] <= (tgt_reg == TGT_DIR_DATA);
      end
    end
  end

  // outputs
  assign rd_data              = rd_data_reg;
  assign rd_valid             = rd_valid_reg;
  assign end_of_transfer_flag = eot_reg;
  assign status_update        = status_reg;
  assign iso_size_a           = iso_size_reg; // RULE1
  assign iso_size_b           = iso_size_reg; // RULE1
  assign int_size             = int_size_reg;
  assign toggle_interval      = toggle_reg;
  // memory handshake is combinational so a word moves in the cycle it is offered
  assign mem_req.sel_a   = (tgt_reg == TGT_ISO_A);
  assign mem_req.sel_b   = (tgt_reg == TGT_ISO_B);
  assign mem_req.sel_int = (tgt_reg == TGT_INT_BUF);
  assign mem_req.direct  = (tgt_reg == TGT_DIR_DATA);
  assign mem_req.addr    = ptr_reg;
  assign mem_req.we      = (state_reg == PS_BUF_WR) && wr_valid;
  assign mem_req.wdata   = wr_data;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_ISO_SAME: assert property (iso_size_a == iso_size_b) // RULE1
    else $error("iso buffer sizes differ");
  // words may follow the command after any gap, so key on the open write state
  AST_ISO_WRITE: assert property (state_reg == PS_REG_WR && tgt_reg == TGT_ISO_SIZE // RULE2
      && wr_valid |=> iso_size_a == $past(wr_data))
    else $error("iso size write not taken");
  AST_A_START: assert property (cmd_valid && cmd_code == 8'h40 |=> ptr_reg == 15'h0000 // RULE4
      && bytes_reg == 17'h00000)
    else $error("buffer A burst did not start at zero");
  AST_PTR_STEP: assert property (xfer && !last && !cmd_valid // RULE12
      |=> ptr_reg == $past(ptr_reg) + 15'h0002)
    else $error("pointer did not advance by one word");
  // a new burst may end again at once, so a second pulse is legal then
  AST_EOT: assert property (last |=> end_of_transfer_flag ##1 // RULE13
      (!end_of_transfer_flag || $past(last)))
    else $error("end of transfer not a single pulse after last word");
  AST_B_STATUS: assert property (last && tgt_reg == TGT_ISO_B |=> status_update == 4'h2) // RULE19
    else $error("buffer B status not updated");
  AST_INT_MAX: assert property (int_size <= 16'h1000) // RULE17
    else $error("interrupt buffer size above limit");
  AST_TOGGLE: assert property (state_reg == PS_REG_WR && tgt_reg == TGT_TOGGLE // RULE16
      && wr_valid |=> toggle_interval == $past(wr_data[3:0]) ##1 $stable(toggle_interval))
    else $error("toggle interval write not taken");
  AST_RESET_DATA: assert property (disable iff (1'b0) sys_rst |=> rd_data == 16'h0000) // RULE14
    else $error("data port not zero after reset");
endmodule

// ==== verif/pbp_mem_model.sv ====
// behavioural buffer memory standing behind the periodic buffer port
// assumes byte addresses below 64 and at most one write a cycle
module pbp_mem_model (
  // clock
  input  wire logic                     clk,
  // buffer access
  input  wire pbp_pkg::pbp_mem_req_type mem_req,
  output logic [15:0]                   mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import pbp_pkg::*;
  logic [15:0] mem_a [32];
  logic [15:0] mem_b [32];
  logic [15:0] mem_i [32];
  always_ff @(posedge clk) begin
    if (mem_req.we && mem_req.sel_a) mem_a[mem_req.addr[5:1]] <= mem_req.wdata;
    if (mem_req.we && mem_req.sel_b) mem_b[mem_req.addr[5:1]] <= mem_req.wdata;
    if (mem_req.we && mem_req.sel_int) mem_i[mem_req.addr[5:1]] <= mem_req.wdata;
  end
  // nothing selected: a pattern that moves, so a stale word never matches
  always_comb begin
    if (mem_req.sel_a) mem_rdata = mem_a[mem_req.addr[5:1]];
    else if (mem_req.sel_b) mem_rdata = mem_b[mem_req.addr[5:1]];
    else if (mem_req.sel_int) mem_rdata = mem_i[mem_req.addr[5:1]];
    else mem_rdata = ~{1'b0, mem_req.addr};
  end
endmodule

// ==== verif/periodic_buffer_port_access_test.sv ====
// self-checking bench: host command and data tasks around the buffer port
// assumes the memory model answers in the cycle of the request
module periodic_buffer_port_access_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pbp_pkg::*;
  logic clk, sys_rst, cmd_valid, wr_valid, rd_req, rd_valid, eot;
  logic [7:0] cmd_code;
  logic [15:0] wr_data, rd_data, tcount, mem_rdata, size_a, size_b, int_size;
  logic [3:0] status, toggle;
  pbp_mem_req_type mem_req;
  int err_count, checks;
  logic [7:0] bcmd [3] = '{CMD_ISO_A, CMD_ISO_B, CMD_INT_BUF};

  pbp_buffer_port DUT (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .transfer_byte_count(tcount),
    .end_of_transfer_flag(eot), .status_update(status), .iso_size_a(size_a),
    .iso_size_b(size_b), .int_size(int_size), .toggle_interval(toggle),
    .mem_req(mem_req), .mem_rdata(mem_rdata));
  pbp_mem_model MEM (.clk(clk), .mem_req(mem_req), .mem_rdata(mem_rdata));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] code);
    @(posedge clk) cmd_valid <= 1'b1;
    cmd_code <= code;
    @(posedge clk) cmd_valid <= 1'b0;
  endtask

  // words held back to back; the host never resends the command
  task automatic wr_burst(input int n, input logic [15:0] base);
    @(posedge clk) wr_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      wr_data <= base + 16'(i);
      @(posedge clk);
    end
    wr_valid <= 1'b0;
    #1;
  endtask

  // leaves the time at one step past the edge that answered
  task automatic rd(input logic [15:0] exp);
    @(posedge clk) rd_req <= 1'b1;
    @(posedge clk) rd_req <= 1'b0;
    #1;
    chk({15'h0, rd_valid}, 16'h0001);
    chk(rd_data, exp);
  endtask

  // the end pulse follows the edge of the last word and lasts one cycle
  task automatic wait_eot(input logic [3:0] exp);
    chk({15'h0, eot}, 16'h0001);
    chk({12'h0, status}, {12'h0, exp});
    @(posedge clk);
    #1;
    chk({15'h0, eot}, 16'h0000);
  endtask

  initial begin
    err_count = 0;
    checks = 0;
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    wr_valid = 1'b0;
    wr_data = 16'h0000;
    rd_req = 1'b0;
    tcount = 16'h0006;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(rd_data, PORT_RST);
    chk({12'h0, toggle}, 16'h0000);
    cmd(CMD_ISO_SIZE); rd(16'h0000);
    cmd(CMD_INT_SIZE); rd(16'h0080);
    cmd(CMD_TOGGLE); rd(16'h0000);
    $display("test reset_values done");
    cmd(CMD_ISO_SIZE | 8'h80); wr_burst(1, 16'h1234);
    chk(size_a, 16'h1234);
    chk(size_b, 16'h1234);
    cmd(CMD_ISO_SIZE); rd(16'h1234);
    cmd(CMD_INT_SIZE | 8'h80); wr_burst(1, 16'h0200);
    cmd(CMD_INT_SIZE); rd(16'h0200);
    cmd(CMD_INT_SIZE | 8'h80); wr_burst(1, 16'h2000);
    chk(int_size, INT_SIZE_MAX);
    cmd(CMD_TOGGLE | 8'h80); wr_burst(1, 16'hffff);
    chk({12'h0, toggle}, 16'h000f);
    cmd(CMD_TOGGLE); rd(16'h000f);
    $display("test size_toggle done");
    for (int b = 0; b < 3; b++) begin
      tcount <= 16'h0006;
      cmd(bcmd[b] | 8'h80);
      wr_burst(3, 16'(b) << 8);
      wait_eot(4'(1 << b));
      cmd(bcmd[b]);
      rd(16'(b) << 8);
      cmd(bcmd[b]);
      for (int i = 0; i < 3; i++) rd((16'(b) << 8) + 16'(i));
      wait_eot(4'(1 << b));
    end
    $display("test buffer_ports done");
    // direct port: start 4, count 4; the model answers a moving pattern there
    cmd(CMD_DIR_SETUP | 8'h80); wr_burst(1, 16'h0004); wr_burst(1, 16'h0004);
    cmd(CMD_DIR_SETUP); rd(16'h0004); rd(16'h0004);
    cmd(CMD_DIR_DATA); rd(16'hfffb); rd(16'hfff9);
    wait_eot(4'h8);
    $display("test direct_port done");
    report_and_stop();
  end

  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
